// ---- include/pczf_map.vh ----
// register map, field layout and timing constants of the pulse counter core
`ifndef PCZF_MAP_VH
`define PCZF_MAP_VH

// register word indices (byte address = index * 4)
`define PCZF_REG_CTRL        4'h0
`define PCZF_REG_STATUS      4'h1
`define PCZF_REG_COUNT       4'h2
`define PCZF_REG_SCALED      4'h3
`define PCZF_REG_MUL         4'h4
`define PCZF_REG_DIV         4'h5
`define PCZF_REG_PRELOAD     4'h6
`define PCZF_REG_POINT       4'h7
`define PCZF_REG_IRQ_STAT    4'h8
`define PCZF_REG_IRQ_EN      4'h9
`define PCZF_REG_IRQ_CLR     4'hA
`define PCZF_REG_CMD         4'hB
`define PCZF_REG_ACT_MUL     4'hC
`define PCZF_REG_ACT_DIV     4'hD
`define PCZF_REG_ACT_PRE     4'hE
`define PCZF_REG_ACT_POINT   4'hF

// ctrl fields
`define PCZF_CTRL_MODE_LO    0
`define PCZF_CTRL_MODE_HI    1
`define PCZF_CTRL_POLICY     2
`define PCZF_CTRL_AUXDIR     3
`define PCZF_CTRL_FILT_LO    4
`define PCZF_CTRL_FILT_HI    7
`define PCZF_CTRL_RESET      8'h00

// counting operations
`define PCZF_OP_SUM          2'h0
`define PCZF_OP_DIFF         2'h1
`define PCZF_OP_QUAD1        2'h2
`define PCZF_OP_QUAD4        2'h3

// command bits (write one)
`define PCZF_CMD_ZERO        0
`define PCZF_CMD_KEY_RESET   1
`define PCZF_CMD_KEY_ENTER   2
`define PCZF_CMD_AS_START    3
`define PCZF_CMD_AS_FINISH   4
`define PCZF_CMD_AS_ABORT    5

// status / irq bits
`define PCZF_EV_ZERO         0
`define PCZF_EV_HI           1
`define PCZF_EV_LO           2
`define PCZF_EV_AS_DONE      3
`define PCZF_EV_W            4

// display range limits
`define PCZF_MAX_DISP        32'sd999999
`define PCZF_MIN_DISP        -32'sd99999

// configuration defaults
`define PCZF_DEF_MUL         32'h00000001
`define PCZF_DEF_DIV         32'h00000001
`define PCZF_DEF_PRE         32'h00000000
`define PCZF_DEF_POINT       3'h0

// timing: 125 MHz clock, raw filter minimum 50 us
`define PCZF_CLK_KHZ         125000
`define PCZF_RAW_US          50
`define PCZF_RAW_CYC         ((`PCZF_RAW_US * `PCZF_CLK_KHZ) / 1000)
// half period of 10 Hz step, cycles = clk / (2 * F)
`define PCZF_FILT_STEP_HZ    10
// highest filter setting; larger settings clamp to it
`define PCZF_FILT_MAX        4'h9
`define PCZF_CLK_HZ          125000000

`endif

// ---- rtl/pczf_debounce.v ----
// stable-level input filter with selectable minimum stable time
`timescale 1ns/1ps
`include "pczf_map.vh"

module pczf_debounce
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// raw input and setting
	input  wire        raw_i,
	input  wire [3:0]  sel_i,
	// filtered level
	output reg         level_o
);

	reg  [1:0]  sync;
	reg  [23:0] cnt;
	reg  [23:0] limit;
	reg  [31:0] lim_full;                 // integer-wide result, cut to the counter width below

	// ********************************
	// limit selection
	// ********************************
	// sel 0 = off (50 us), 1..9 = 10..90 Hz, half period; larger values clamp to 90 Hz
	always @*
	begin
		if (sel_i == 4'h0)
			lim_full = `PCZF_RAW_CYC;
		else if (sel_i > `PCZF_FILT_MAX)
			lim_full = `PCZF_CLK_HZ / (2 * `PCZF_FILT_MAX * `PCZF_FILT_STEP_HZ);
		else
			lim_full = `PCZF_CLK_HZ / (2 * `PCZF_FILT_STEP_HZ * sel_i);
		// longest limit (10 Hz) still fits in 24 bits
		limit = lim_full[23:0];
	end

	// ********************************
	// synchroniser and stability counter
	// ********************************
	// accept stable level only
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync    <= 2'h0;
			cnt     <= 24'h000000;
			level_o <= 1'b0;
		end
		else
		begin
			sync <= {sync[0], raw_i};
			if (sync[1] == level_o)
				cnt <= 24'h000000;             // excursion ended, discard
			else if (cnt + 24'h000001 >= limit)
			begin
				level_o <= sync[1];
				cnt     <= 24'h000000;
			end
			else
				cnt <= cnt + 24'h000001;
		end
	end

endmodule

// ---- rtl/pczf_counter.v ----
// pulse / quadrature counter core with zeroing, preload, update policy and auto-scaling
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "pczf_map.vh"

// Contract
// - zero on key, clear input, serial preset
// - zeroing loads the preload value
// - counting continues during menu; input max 8kHz
// - apply-on-clear holds settings until zeroing
// - apply-now uses settings immediately
// - aux input reverses count direction; in the sum operation the code keeps counting up
// - auto-scaling loads defaults, clears, counts div
// - finish stores div, mul, point; preload zero
// - abort restores mul, div, point only
// - filter 10..90 Hz, stable half period
// - filter off: 10 kHz, 50 us levels
// - quick view times out after 5 s
// - four counting operation encodings
// - flag high and low overrange
module pczf_counter
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [5:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output wire        ack_o,
	// input pins
	input  wire        in_a_i,
	input  wire        in_b_i,
	input  wire        aux_i,
	input  wire        clear_i,
	// quick view keys and state
	input  wire        key_up_i,
	input  wire        key_down_i,
	output reg  [2:0]  quick_view_o,
	// interrupt and warnings
	output wire        irq_o,
	output reg         over_hi_o,
	output reg         over_lo_o
);

	parameter QV_TIMEOUT = 32'd625000000; // 5 s at 125 MHz

	// ********************************
	// state and configuration
	// ********************************
	localparam AS_IDLE = 3'b001;
	localparam AS_RUN  = 3'b010;
	localparam AS_HOLD = 3'b100;

	reg  [7:0]  ctrl;
	reg  [31:0] mul, div, pre;            // written settings
	reg  [2:0]  point;
	reg  [31:0] a_mul, a_div, a_pre;      // active settings
	reg  [2:0]  a_point;
	reg  [31:0] s_mul, s_div;             // saved before auto-scaling
	reg  [2:0]  s_point;
	reg  signed [31:0] count;
	reg  signed [31:0] scaled;
	reg  [2:0]  as_state;
	reg  [`PCZF_EV_W-1:0] ev_stat, ev_en;
	reg  [1:0]  clr_sync, up_sync, dn_sync;
	reg         clr_q, up_q, dn_q, key_armed;
	reg  [31:0] qv_cnt;
	reg         a_q, b_q, aux_q;
	reg         ack_r;

	wire fa, fb, faux;
	wire [3:0] filt = ctrl[`PCZF_CTRL_FILT_HI:`PCZF_CTRL_FILT_LO];

	pczf_debounce u_fa (.clk_i(clk_i), .rst_i(rst_i), .raw_i(in_a_i), .sel_i(filt), .level_o(fa));
	pczf_debounce u_fb (.clk_i(clk_i), .rst_i(rst_i), .raw_i(in_b_i), .sel_i(filt), .level_o(fb));
	// aux filter fixed at the off setting, 50 us, whatever the filter setting
	pczf_debounce u_fx (.clk_i(clk_i), .rst_i(rst_i), .raw_i(aux_i), .sel_i(4'h0), .level_o(faux));

	// ********************************
	// bus decode
	// ********************************
	wire        bus_req = cyc_i & stb_i & ~ack_r;
	wire        wr      = bus_req & we_i & sel_i[0];
	wire [3:0]  idx     = adr_i[5:2];
	assign ack_o = ack_r;

	// ********************************
	// pulse decoding
	// ********************************
	wire rise_a = fa & ~a_q;
	wire rise_b = fb & ~b_q;
	wire edge_a = fa ^ a_q;
	wire edge_b = fb ^ b_q;
	wire [1:0] op = ctrl[`PCZF_CTRL_MODE_HI:`PCZF_CTRL_MODE_LO];
	reg  signed [2:0] step;

	always @*
	begin
		step = 3'sd0;
		case (op)
			`PCZF_OP_SUM:   step = $signed({2'b00, rise_a}) + $signed({2'b00, rise_b});
			`PCZF_OP_DIFF:  step = $signed({2'b00, rise_a}) - $signed({2'b00, rise_b});
			`PCZF_OP_QUAD1: step = rise_a ? (fb ? -3'sd1 : 3'sd1) : 3'sd0;
			`PCZF_OP_QUAD4:
			begin
				if (edge_a)
					step = (fa ^ fb) ? 3'sd1 : -3'sd1;
				else if (edge_b)
					step = (fa ^ fb) ? -3'sd1 : 3'sd1;
			end
			default: step = 3'sd0;
		endcase
		if (ctrl[`PCZF_CTRL_AUXDIR] && faux && op != `PCZF_OP_SUM)
			step = -step;
	end

	// ********************************
	// commands and zeroing sources
	// ********************************
	wire cmd_wr  = wr & (idx == `PCZF_REG_CMD);
	wire c_zero  = cmd_wr & dat_i[`PCZF_CMD_ZERO];
	wire c_kres  = cmd_wr & dat_i[`PCZF_CMD_KEY_RESET];
	wire c_kent  = cmd_wr & dat_i[`PCZF_CMD_KEY_ENTER];
	wire c_start = cmd_wr & dat_i[`PCZF_CMD_AS_START] & (as_state == AS_IDLE);
	wire c_fin   = cmd_wr & dat_i[`PCZF_CMD_AS_FINISH] & (as_state != AS_IDLE);
	wire c_abort = cmd_wr & dat_i[`PCZF_CMD_AS_ABORT] & (as_state != AS_IDLE);
	wire ext_clr = clr_sync[1] & ~clr_q;
	wire zero_ev = c_zero | (key_armed & c_kent) | ext_clr;
	wire policy_now = ctrl[`PCZF_CTRL_POLICY];

	// ********************************
	// counting and settings
	// ********************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= `PCZF_CTRL_RESET;
			mul <= `PCZF_DEF_MUL;    div <= `PCZF_DEF_DIV;    pre <= `PCZF_DEF_PRE;    point <= `PCZF_DEF_POINT;
			a_mul <= `PCZF_DEF_MUL;  a_div <= `PCZF_DEF_DIV;  a_pre <= `PCZF_DEF_PRE;  a_point <= `PCZF_DEF_POINT;
			s_mul <= `PCZF_DEF_MUL;  s_div <= `PCZF_DEF_DIV;  s_point <= `PCZF_DEF_POINT;
			count <= 32'sh00000000;
			as_state <= AS_IDLE;
			a_q <= 1'b0;
			b_q <= 1'b0;
			key_armed <= 1'b0;
		end
		else
		begin
			a_q <= fa;
			b_q <= fb;
			// keyboard reset waits for enter confirmation
			if (c_kres)
				key_armed <= 1'b1;
			else if (c_kent)
				key_armed <= 1'b0;
			if (wr && idx == `PCZF_REG_CTRL)
				ctrl <= dat_i[7:0];
			if (wr && idx == `PCZF_REG_MUL)
				mul <= dat_i;
			if (wr && idx == `PCZF_REG_DIV)
				div <= dat_i;
			if (wr && idx == `PCZF_REG_PRELOAD)
				pre <= dat_i;
			if (wr && idx == `PCZF_REG_POINT)
				point <= dat_i[2:0];
			if (policy_now && as_state == AS_IDLE)
			begin
				a_mul <= mul;
				a_div <= div;
				a_pre <= pre;
				a_point <= point;
			end
			count <= count + {{29{step[2]}}, step};
			case (as_state)
				AS_IDLE:
				begin
					if (c_start)
					begin
						s_mul <= a_mul;
						s_div <= a_div;
						s_point <= a_point;
						a_mul <= `PCZF_DEF_MUL;
						a_div <= `PCZF_DEF_DIV;
						a_pre <= `PCZF_DEF_PRE;
						a_point <= `PCZF_DEF_POINT;
						count <= 32'sh00000000;
						as_state <= AS_RUN;
					end
					else if (zero_ev)
					begin
						a_mul <= mul;
						a_div <= div;
						a_pre <= pre;
						a_point <= point;
						count <= $signed(pre);
					end
				end
				AS_RUN:
				begin
					// learned div is the pulse count; mul/point written by software
					if (c_abort)
						as_state <= AS_HOLD;
					else if (c_fin)
					begin
						mul <= mul;
						div <= count[31:0];
						a_div <= count[31:0];
						a_mul <= mul;
						a_point <= point;
						pre <= `PCZF_DEF_PRE;
						a_pre <= `PCZF_DEF_PRE;
						as_state <= AS_IDLE;
					end
				end
				AS_HOLD:
				begin
					a_mul <= s_mul;
					a_div <= s_div;
					a_point <= s_point;
					mul <= s_mul;
					div <= s_div;
					point <= s_point;
					as_state <= AS_IDLE;
				end
				default: as_state <= AS_IDLE;
			endcase
		end
	end

	// ********************************
	// scaling and overrange
	// ********************************
	// scale by mul/div; divide shared once, guarded against zero divisor
	wire signed [63:0] prod = count * $signed(a_mul);
	wire signed [63:0] quot = (a_div == 32'h0) ? prod : prod / $signed({32'h0, a_div});

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scaled <= 32'sh00000000;
			over_hi_o <= 1'b0;
			over_lo_o <= 1'b0;
		end
		else
		begin
			scaled <= quot[31:0];
			over_hi_o <= quot > $signed({{32{1'b0}}, `PCZF_MAX_DISP});
			over_lo_o <= quot < $signed({{32{1'b1}}, `PCZF_MIN_DISP});
		end
	end

	// ********************************
	// quick view timeout and input syncs
	// ********************************
	// 5 s quick view timeout
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clr_sync <= 2'h0; up_sync <= 2'h0; dn_sync <= 2'h0;
			clr_q <= 1'b0; up_q <= 1'b0; dn_q <= 1'b0;
			quick_view_o <= 3'h0;
			qv_cnt <= 32'h0;
		end
		else
		begin
			clr_sync <= {clr_sync[0], clear_i};
			up_sync <= {up_sync[0], key_up_i};
			dn_sync <= {dn_sync[0], key_down_i};
			clr_q <= clr_sync[1];
			up_q <= up_sync[1];
			dn_q <= dn_sync[1];
			if ((up_sync[1] & ~up_q) | (dn_sync[1] & ~dn_q))
			begin
				quick_view_o <= quick_view_o + 3'h1;
				qv_cnt <= 32'h0;
			end
			else if (quick_view_o != 3'h0)
			begin
				if (qv_cnt >= QV_TIMEOUT - 32'h1)
					quick_view_o <= 3'h0;
				else
					qv_cnt <= qv_cnt + 32'h1;
			end
		end
	end

	// ********************************
	// events and interrupt
	// ********************************
	wire [`PCZF_EV_W-1:0] ev = {c_fin, over_lo_o, over_hi_o, zero_ev | c_start};
	wire [`PCZF_EV_W-1:0] clr_m = (wr && idx == `PCZF_REG_IRQ_CLR) ? dat_i[`PCZF_EV_W-1:0] : {`PCZF_EV_W{1'b0}};

	// set beats clear in the same cycle
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_stat <= {`PCZF_EV_W{1'b0}};
			ev_en <= {`PCZF_EV_W{1'b0}};
		end
		else
		begin
			ev_stat <= (ev_stat & ~clr_m) | ev;
			if (wr && idx == `PCZF_REG_IRQ_EN)
				ev_en <= dat_i[`PCZF_EV_W-1:0];
		end
	end
	assign irq_o = |(ev_stat & ev_en);

	// ********************************
	// read data and ack
	// ********************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_o <= 32'h0;
		end
		else
		begin
			ack_r <= bus_req;
			if (bus_req && !we_i)
			begin
				case (idx)
					`PCZF_REG_CTRL:      dat_o <= {24'h0, ctrl};
					`PCZF_REG_STATUS:    dat_o <= {26'h0, as_state, key_armed, over_lo_o, over_hi_o};
					`PCZF_REG_COUNT:     dat_o <= count;
					`PCZF_REG_SCALED:    dat_o <= scaled;
					`PCZF_REG_MUL:       dat_o <= mul;
					`PCZF_REG_DIV:       dat_o <= div;
					`PCZF_REG_PRELOAD:   dat_o <= pre;
					`PCZF_REG_POINT:     dat_o <= {29'h0, point};
					`PCZF_REG_IRQ_STAT:  dat_o <= {28'h0, ev_stat};
					`PCZF_REG_IRQ_EN:    dat_o <= {28'h0, ev_en};
					`PCZF_REG_ACT_MUL:   dat_o <= a_mul;
					`PCZF_REG_ACT_DIV:   dat_o <= a_div;
					`PCZF_REG_ACT_PRE:   dat_o <= a_pre;
					`PCZF_REG_ACT_POINT: dat_o <= {29'h0, a_point};
					default:             dat_o <= 32'h0;
				endcase
			end
		end
	end

endmodule

// ---- tb/pczf_counter_chk.sv ----
// port-level assertion checker for the pulse counter core
`timescale 1ns/1ps
module pczf_counter_chk
#(
	parameter QV_TIMEOUT = 32'd625000000
)
(
	// clock and reset
	input logic        clk_i,
	input logic        rst_i,
	// wishbone
	input logic        cyc_i,
	input logic        stb_i,
	input logic        we_i,
	input logic [5:0]  adr_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	// keys and outputs
	input logic        key_up_i,
	input logic        key_down_i,
	input logic [2:0]  quick_view_o,
	input logic        irq_o,
	input logic        over_hi_o,
	input logic        over_lo_o
);
	// ****************************************
	// bus and output relations
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_taken;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_qv_opens;
		quick_view_o != 3'h0 && $past(quick_view_o) == 3'h0;
	endsequence
	// idle quick view cycles; keys pass a two-flop synchroniser, so a few cycles of margin
	logic [31:0] qv_idle;
	always @(posedge clk_i)
	begin
		if (rst_i || quick_view_o == 3'h0 || key_up_i || key_down_i)
			qv_idle <= 32'h0;
		else
			qv_idle <= qv_idle + 32'h1;
	end
	AST_ACK_TAKEN: assert property (s_taken |=> ack_o) else $error("ack missing after request");
	AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
	AST_DAT_HOLD: assert property (!$stable(dat_o) |-> ack_o) else $error("read data moved without ack");
	AST_RST_QUIET: assert property ($fell(rst_i) |-> (quick_view_o == 3'h0 && !over_hi_o && !over_lo_o && !irq_o))
		else $error("outputs not quiet after reset");
	AST_IRQ_MASK: assert property ((ack_o && we_i && adr_i == 6'h24 && dat_i == 32'h0) |=> !irq_o)
		else $error("interrupt with all sources masked");
	AST_HI_LO: assert property (!(over_hi_o && over_lo_o)) else $error("both overrange flags");
	AST_QV_FROM_KEY: assert property (s_qv_opens |-> ($past(key_up_i, 3) || $past(key_down_i, 3)))
		else $error("quick view without key");
	AST_QV_BOUND: assert property (qv_idle <= QV_TIMEOUT + 32'h8) else $error("quick view never times out");
endmodule

bind pczf_counter pczf_counter_chk #(.QV_TIMEOUT(QV_TIMEOUT)) pczf_counter_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.key_up_i(key_up_i), .key_down_i(key_down_i), .quick_view_o(quick_view_o), .irq_o(irq_o),
	.over_hi_o(over_hi_o), .over_lo_o(over_lo_o));

// ---- tb/pczf_pulse_src.sv ----
// pulse source model driving the counting inputs
`timescale 1ns/1ps
module pczf_pulse_src
(
	// clock
	input  logic        clk_i,
	// request
	input  logic        go_i,
	input  logic        chan_i,
	input  logic [15:0] len_i,
	// pulse lines and status
	output logic        a_o,
	output logic        b_o,
	output logic        busy_o
);
	// ****************************************
	// one high phase then one low phase
	// ****************************************
	logic [16:0] cnt = 17'h0;
	logic        ch = 1'b0;
	logic [15:0] len = 16'h0;
	initial busy_o = 1'b0;
	// stable equal levels, rate kept low
	always @(posedge clk_i)
	begin
		if (go_i && !busy_o)
		begin
			busy_o <= 1'b1;
			ch <= chan_i;
			len <= len_i;
			cnt <= 17'h0;
		end
		else if (busy_o)
		begin
			cnt <= cnt + 17'h1;
			if (cnt == {len, 1'b0})
				busy_o <= 1'b0;
		end
	end
	// unused line rests low, as a push-pull source would leave it
	assign a_o = busy_o && !ch && cnt < {1'b0, len};
	assign b_o = busy_o && ch && cnt < {1'b0, len};
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the pulse counter core
`timescale 1ns/1ps
module testbench;
	// ****************************************
	// signals and instances
	// ****************************************
	logic        clk_i, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o;
	logic        in_a_i, in_b_i, aux_i = 1'b0, clear_i = 1'b0, key_up_i = 1'b0, over_hi_o, over_lo_o;
	logic        go_i = 1'b0, chan_i = 1'b0, busy_o, key_down_i = 1'b0;
	logic [5:0]  adr_i = 6'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rdata;
	logic [15:0] len_i = 16'h0;
	logic [2:0]  quick_view_o;
	int          failures = 0, checks_done = 0;

	pczf_counter #(.QV_TIMEOUT(32'd100)) pczf_counter_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.in_a_i(in_a_i), .in_b_i(in_b_i), .aux_i(aux_i), .clear_i(clear_i), .key_up_i(key_up_i),
		.key_down_i(key_down_i), .quick_view_o(quick_view_o), .irq_o(irq_o), .over_hi_o(over_hi_o),
		.over_lo_o(over_lo_o));
	pczf_pulse_src pczf_pulse_src_i (.clk_i(clk_i), .go_i(go_i), .chan_i(chan_i), .len_i(len_i),
		.a_o(in_a_i), .b_o(in_b_i), .busy_o(busy_o));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1)
			failures++;
		rdata = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rdata);
	endtask
	task automatic pulse(input logic ch, input logic [15:0] len);
		int n;
		@(posedge clk_i);
		go_i <= 1'b1;
		chan_i <= ch;
		len_i <= len;
		@(posedge clk_i);
		go_i <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (busy_o === 1'b1 && n < 40000);
		if (busy_o !== 1'b0)
			failures++;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic conclude;
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		rdc(6'h00, 32'h0, "ctrl");
		rdc(6'h04, 32'h8, "status");
		rdc(6'h30, 32'h1, "act_mul");
		rdc(6'h34, 32'h1, "act_div");
		rdc(6'h3C, 32'h0, "act_point");
		wb(1'b1, 6'h08, 32'h55);
		rdc(6'h08, 32'h0, "count_ro");
	endtask
	task automatic t_zero;
		wb(1'b1, 6'h18, 32'h5);
		rdc(6'h38, 32'h0, "act_pre_pending");
		wb(1'b1, 6'h24, 32'h1);
		wb(1'b1, 6'h2C, 32'h1);
		rdc(6'h08, 32'h5, "count_serial");
		rdc(6'h38, 32'h5, "act_pre_applied");
		chk("irq_set", 32'h1, {31'h0, irq_o});
		wb(1'b1, 6'h28, 32'h1);
		chk("irq_clr", 32'h0, {31'h0, irq_o});
		wb(1'b1, 6'h24, 32'h0);
		wb(1'b1, 6'h18, 32'h9);
		wb(1'b1, 6'h2C, 32'h2);
		wb(1'b1, 6'h2C, 32'h4);
		rdc(6'h08, 32'h9, "count_key");
		chk("irq_masked", 32'h0, {31'h0, irq_o});
		rdc(6'h20, 32'h1, "irq_sticky");
		wb(1'b1, 6'h18, 32'h3);
		@(posedge clk_i);
		clear_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		clear_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdc(6'h08, 32'h3, "count_clear_pin");
	endtask
	task automatic t_count;
		wb(1'b1, 6'h00, 32'h5);
		wb(1'b1, 6'h18, 32'h0);
		wb(1'b1, 6'h2C, 32'h1);
		pulse(1'b0, 16'h1EDC);
		rdc(6'h08, 32'h1, "count_a");
		pulse(1'b1, 16'h1EDC);
		rdc(6'h08, 32'h0, "count_b_down");
		pulse(1'b0, 16'h0064);
		rdc(6'h08, 32'h0, "count_glitch");
		wb(1'b1, 6'h00, 32'hD);
		aux_i <= 1'b1;
		repeat (6400) @(posedge clk_i);
		pulse(1'b0, 16'h1EDC);
		rdc(6'h08, 32'hFFFFFFFF, "count_aux_rev");
		aux_i <= 1'b0;
		repeat (6400) @(posedge clk_i);
	endtask
	task automatic t_over;
		wb(1'b1, 6'h18, 32'h000F423F);
		wb(1'b1, 6'h2C, 32'h1);
		rdc(6'h0C, 32'h000F423F, "scaled_max");
		chk("over_hi_edge", 32'h0, {31'h0, over_hi_o});
		wb(1'b1, 6'h18, 32'h000F4240);
		wb(1'b1, 6'h2C, 32'h1);
		rdc(6'h0C, 32'h000F4240, "scaled_hi");
		chk("over_hi", 32'h1, {31'h0, over_hi_o});
		wb(1'b1, 6'h18, 32'hFFFE7960);
		wb(1'b1, 6'h2C, 32'h1);
		rdc(6'h0C, 32'hFFFE7960, "scaled_lo");
		chk("over_lo", 32'h1, {31'h0, over_lo_o});
		wb(1'b1, 6'h18, 32'h0);
		wb(1'b1, 6'h2C, 32'h1);
	endtask
	task automatic t_auto;
		wb(1'b1, 6'h10, 32'h7);
		rdc(6'h30, 32'h7, "act_mul_now");
		wb(1'b1, 6'h2C, 32'h8);
		rdc(6'h30, 32'h1, "as_default_mul");
		rdc(6'h08, 32'h0, "as_count_clear");
		wb(1'b1, 6'h2C, 32'h20);
		rdc(6'h30, 32'h7, "abort_mul");
		rdc(6'h34, 32'h1, "abort_div");
		wb(1'b1, 6'h18, 32'h6);
		wb(1'b1, 6'h14, 32'h3);
		wb(1'b1, 6'h2C, 32'h8);
		pulse(1'b0, 16'h1EDC);
		wb(1'b1, 6'h10, 32'h4);
		wb(1'b1, 6'h1C, 32'h2);
		wb(1'b1, 6'h2C, 32'h10);
		rdc(6'h34, 32'h1, "as_div");
		rdc(6'h14, 32'h1, "as_div_stored");
		rdc(6'h30, 32'h4, "as_mul");
		rdc(6'h3C, 32'h2, "as_point");
		rdc(6'h38, 32'h0, "as_pre");
	endtask
	task automatic t_qv;
		int n;
		@(posedge clk_i);
		key_up_i <= 1'b1;
		for (n = 0; n < 7000 && quick_view_o === 3'h0; n++)
			@(posedge clk_i);
		key_up_i <= 1'b0;
		chk("qv_open", 32'h1, {29'h0, quick_view_o});
		key_down_i <= 1'b1;
		for (n = 0; n < 20 && quick_view_o === 3'h1; n++)
			@(posedge clk_i);
		key_down_i <= 1'b0;
		chk("qv_next", 32'h2, {29'h0, quick_view_o});
		for (n = 0; n < 7000 && quick_view_o !== 3'h0; n++)
			@(posedge clk_i);
		chk("qv_close", 32'h0, {29'h0, quick_view_o});
	endtask

	// ****************************************
	// clock, sequence and watchdog
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_zero();
		t_count();
		t_over();
		t_auto();
		t_qv();
		conclude();
	end
	// the whole run needs about 80000 cycles
	initial
	begin
		repeat (95000) @(posedge clk_i);
		failures++;
		conclude();
	end
endmodule
